// File: verilog/sshd_pkg.sv
// Purpose: Constants for the half-duplex clocked serial transmit port and its far end
// Assumes: 100 MHz system clock, APB register access, byte registers in aligned words
// Notes: Summary of operation below
`default_nettype none

package sshd_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_BAUD_CTL = 8'h00;
  localparam logic [7:0] ADDR_RX_CTL = 8'h04;
  localparam logic [7:0] ADDR_DIV_LO = 8'h08;
  localparam logic [7:0] ADDR_DIV_HI = 8'h0C;
  localparam logic [7:0] ADDR_TX_HOLD = 8'h10;
  localparam logic [7:0] ADDR_TX_CTL = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CTL = 8'h18;

  // Register indices after decode
  localparam logic [2:0] IDX_BAUD_CTL = 3'h0;
  localparam logic [2:0] IDX_RX_CTL = 3'h1;
  localparam logic [2:0] IDX_DIV_LO = 3'h2;
  localparam logic [2:0] IDX_DIV_HI = 3'h3;
  localparam logic [2:0] IDX_TX_HOLD = 3'h4;
  localparam logic [2:0] IDX_TX_CTL = 3'h5;
  localparam logic [2:0] IDX_IRQ_CTL = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Field positions
  localparam int BAUD_POL_BIT = 4;
  localparam int BAUD_WIDE_BIT = 3;
  localparam int RX_PORT_EN_BIT = 7;
  localparam int RX_SINGLE_BIT = 5;
  localparam int RX_CONT_BIT = 4;
  localparam int TX_SRC_BIT = 7;
  localparam int TX_NINE_BIT = 6;
  localparam int TX_EN_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HSPEED_BIT = 2;
  localparam int TX_EMPTY_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam int IRQ_TRANSMIT_IRQ_ENABLE_BIT = 0;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE_BIT = 1;
  localparam int IRQ_GIE_BIT = 2;
  localparam int IRQ_FLAG_BIT = 3;

  // Writable bit masks
  localparam logic [7:0] BAUD_CTL_MASK = 8'h18;
  localparam logic [7:0] RX_CTL_MASK = 8'hB0;
  localparam logic [7:0] TX_CTL_MASK = 8'hF5;
  localparam logic [7:0] IRQ_CTL_MASK = 8'h07;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;

  // Character lengths
  localparam logic [3:0] CHAR_BITS = 4'h8;
  localparam logic [3:0] LONG_BITS = 4'h9;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam logic [7:0] PEER_HALF_CYC = 8'((LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                             / (2 * CLK_PERIOD_NS));

  // Far end sequencing
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_RUN = 2'b01,
    PS_DONE = 2'b10
  } sshd_peer_state_e;
endpackage

`default_nettype wire

// File: verilog/sshd_if.sv
// Purpose: Shared clock and data lines between the serial port and its far end
// Assumes: Each end gives output and enable per line; the lines resolve here
// Notes: An undriven line reads high, as with a pull-up
`default_nettype none

interface sshd_if;
  logic devCkOut;
  logic devCkOe;
  logic devDtOut;
  logic devDtOe;
  logic peerCkOut;
  logic peerCkOe;
  logic peerDtOut;
  logic peerDtOe;
  logic ck;
  logic dt;

  assign ck = devCkOe ? devCkOut : (peerCkOe ? peerCkOut : 1'b1);
  assign dt = devDtOe ? devDtOut : (peerDtOe ? peerDtOut : 1'b1);

  modport dev (output devCkOut, output devCkOe, output devDtOut, output devDtOe,
               input ck, input dt);
  modport peer (output peerCkOut, output peerCkOe, output peerDtOut, output peerDtOe,
                input ck, input dt);
endinterface

`default_nettype wire

// File: verilog/sshd_shifter.sv
// Purpose: Transmit shifter, least significant bit first
// Assumes: lead and trail are single-cycle clock edge events
// Notes: A trail with no preceding lead is ignored
`default_nettype none

module sshd_shifter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Load side
  input wire logic load,
  input wire logic [8:0] word,
  input wire logic nine,
  // Edge events
  input wire logic lead,
  input wire logic trail,
  // Outputs
  output logic bitOut,
  output logic busy
);
  logic [8:0] shReg_q;
  logic [3:0] remain_q;
  logic armed_q;

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      shReg_q <= 9'h000;
      remain_q <= 4'h0;
      armed_q <= 1'b0;
      busy <= 1'b0;
      bitOut <= 1'b1;
    end else if (load) begin
      shReg_q <= word;
      remain_q <= nine ? sshd_pkg::LONG_BITS : sshd_pkg::CHAR_BITS;
      armed_q <= 1'b0;
      busy <= 1'b1;
    end else if (busy) begin
      if (lead) begin
        bitOut <= shReg_q[0];
        shReg_q <= {1'b0, shReg_q[8:1]};
        armed_q <= 1'b1;
      end else if (trail && armed_q) begin
        armed_q <= 1'b0;
        remain_q <= remain_q - 4'h1;
        if (remain_q == 4'h1) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule // sshd_shifter

`default_nettype wire

// File: verilog/sshd_port.sv
// Purpose: Clocked half-duplex serial port, transmit side, with APB registers
// Assumes: APB slave, one wait state; link clock sampled by two flip-flops
// Notes: Receive path is not built; receive direction only releases the data pin
//
// The register offsets and register access over APB were decided locally.
`default_nettype none

module sshd_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state and wake
  input wire logic sleep,
  output logic wakeReq,
  output logic irqReq,
  // Link
  sshd_if.dev link
);
  function automatic logic [2:0] regIdx(input logic [7:0] a);
    case (a)
      sshd_pkg::ADDR_BAUD_CTL: regIdx = sshd_pkg::IDX_BAUD_CTL;
      sshd_pkg::ADDR_RX_CTL: regIdx = sshd_pkg::IDX_RX_CTL;
      sshd_pkg::ADDR_DIV_LO: regIdx = sshd_pkg::IDX_DIV_LO;
      sshd_pkg::ADDR_DIV_HI: regIdx = sshd_pkg::IDX_DIV_HI;
      sshd_pkg::ADDR_TX_HOLD: regIdx = sshd_pkg::IDX_TX_HOLD;
      sshd_pkg::ADDR_TX_CTL: regIdx = sshd_pkg::IDX_TX_CTL;
      sshd_pkg::ADDR_IRQ_CTL: regIdx = sshd_pkg::IDX_IRQ_CTL;
      default: regIdx = sshd_pkg::IDX_NONE;
    endcase
  endfunction

  logic [7:0] baudCtl_q;
  logic [7:0] rxCtl_q;
  logic [7:0] txCtl_q;
  logic [7:0] irqCtl_q;
  logic [15:0] div_q;
  logic [8:0] holdWord_q;
  logic holdFull_q;
  logic [15:0] baudCnt_q;
  logic ckAct_q;
  logic ckS1_q;
  logic ckS2_q;
  logic ckS3_q;
  logic [2:0] idx;
  logic setupAcc;
  logic wr;
  logic holdWr;
  logic portEn;
  logic clocked;
  logic isMaster;
  logic txDir;
  logic txActive;
  logic pol;
  logic nineSel;
  logic busy;
  logic shBit;
  logic xfer;
  logic txFlag;
  logic [15:0] halfDiv;
  logic baudEnd;
  logic masterRun;
  logic lead;
  logic trail;
  logic slaveAct;
  logic slavePrev;
  logic [7:0] rdVal;

  assign idx = regIdx(paddr);
  assign setupAcc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign holdWr = wr && (idx == sshd_pkg::IDX_TX_HOLD);
  assign portEn = rxCtl_q[sshd_pkg::RX_PORT_EN_BIT];
  assign clocked = txCtl_q[sshd_pkg::TX_SYNC_BIT];
  assign isMaster = clocked && txCtl_q[sshd_pkg::TX_SRC_BIT];
  assign txDir = !rxCtl_q[sshd_pkg::RX_SINGLE_BIT] && !rxCtl_q[sshd_pkg::RX_CONT_BIT];
  assign txActive = portEn && clocked && txDir && txCtl_q[sshd_pkg::TX_EN_BIT];
  assign pol = baudCtl_q[sshd_pkg::BAUD_POL_BIT];
  assign nineSel = txCtl_q[sshd_pkg::TX_NINE_BIT];
  assign xfer = holdFull_q && !busy && txActive;
  assign txFlag = !holdFull_q && txCtl_q[sshd_pkg::TX_EN_BIT];
  assign halfDiv = baudCtl_q[sshd_pkg::BAUD_WIDE_BIT] ? div_q : {8'h00, div_q[7:0]};

  // Register read view; shifter contents never appear here
  always_comb begin
    case (idx)
      sshd_pkg::IDX_BAUD_CTL: rdVal = baudCtl_q;
      sshd_pkg::IDX_RX_CTL: rdVal = rxCtl_q;
      sshd_pkg::IDX_DIV_LO: rdVal = div_q[7:0];
      sshd_pkg::IDX_DIV_HI: rdVal = div_q[15:8];
      sshd_pkg::IDX_TX_CTL: begin
        rdVal = txCtl_q;
        rdVal[sshd_pkg::TX_EMPTY_BIT] = !busy;
      end
      sshd_pkg::IDX_IRQ_CTL: begin
        rdVal = irqCtl_q;
        rdVal[sshd_pkg::IRQ_FLAG_BIT] = txFlag;
      end
      default: rdVal = 8'h00;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupAcc;
      prdata <= setupAcc ? {24'h00_0000, rdVal} : 32'h0000_0000;
      pslverr <= setupAcc && (idx == sshd_pkg::IDX_NONE);
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      baudCtl_q <= sshd_pkg::REG_RESET;
      rxCtl_q <= sshd_pkg::REG_RESET;
      txCtl_q <= sshd_pkg::REG_RESET;
      irqCtl_q <= sshd_pkg::REG_RESET;
      div_q <= sshd_pkg::DIV_RESET;
    end else if (wr) begin
      case (idx)
        sshd_pkg::IDX_BAUD_CTL: baudCtl_q <= pwdata[7:0] & sshd_pkg::BAUD_CTL_MASK;
        sshd_pkg::IDX_RX_CTL: rxCtl_q <= pwdata[7:0] & sshd_pkg::RX_CTL_MASK;
        sshd_pkg::IDX_DIV_LO: div_q[7:0] <= pwdata[7:0];
        sshd_pkg::IDX_DIV_HI: div_q[15:8] <= pwdata[7:0];
        sshd_pkg::IDX_TX_CTL: txCtl_q <= pwdata[7:0] & sshd_pkg::TX_CTL_MASK;
        sshd_pkg::IDX_IRQ_CTL: irqCtl_q <= pwdata[7:0] & sshd_pkg::IRQ_CTL_MASK;
        default: ;
      endcase
    end
  end

  // Holding register; a write in the transfer cycle keeps it full
  always_ff @(posedge clk) begin
    if (rst || !portEn) begin
      holdFull_q <= 1'b0;
      holdWord_q <= 9'h000;
    end else begin
      holdFull_q <= (holdFull_q && !xfer) || holdWr;
      if (holdWr) begin
        holdWord_q <= {txCtl_q[sshd_pkg::TX_NINTH_BIT] && nineSel, pwdata[7:0]};
      end
    end
  end

  // Master shift clock; the system clock stops in sleep
  assign masterRun = isMaster && txActive && busy;
  assign baudEnd = masterRun && !sleep && (baudCnt_q == halfDiv);

  always_ff @(posedge clk) begin
    if (rst || !masterRun) begin
      baudCnt_q <= 16'h0000;
      ckAct_q <= 1'b0;
    end else if (!sleep) begin
      if (baudEnd) begin
        baudCnt_q <= 16'h0000;
        ckAct_q <= !ckAct_q;
      end else begin
        baudCnt_q <= baudCnt_q + 16'h0001;
      end
    end
  end

  // External clock for slave transmit
  always_ff @(posedge clk) begin
    if (rst) begin
      ckS1_q <= 1'b0;
      ckS2_q <= 1'b0;
      ckS3_q <= 1'b0;
    end else begin
      ckS1_q <= link.ck;
      ckS2_q <= ckS1_q;
      ckS3_q <= ckS2_q;
    end
  end

  assign slaveAct = ckS2_q ^ pol;
  assign slavePrev = ckS3_q ^ pol;

  // Edge events; slave shifts on in sleep as well
  always_comb begin
    if (isMaster) begin
      lead = baudEnd && !ckAct_q;
      trail = baudEnd && ckAct_q;
    end else begin
      lead = txActive && clocked && slaveAct && !slavePrev;
      trail = txActive && clocked && !slaveAct && slavePrev;
    end
  end

  sshd_shifter u_shifter (
    .clk(clk),
    .rst(rst),
    .clr(!txActive),
    .load(xfer),
    .word(holdWord_q),
    .nine(nineSel),
    .lead(lead),
    .trail(trail),
    .bitOut(shBit),
    .busy(busy)
  );

  // Pin drive
  always_ff @(posedge clk) begin
    if (rst) begin
      link.devCkOut <= 1'b0;
      link.devCkOe <= 1'b0;
      link.devDtOut <= 1'b1;
      link.devDtOe <= 1'b0;
    end else begin
      link.devCkOut <= pol ^ ckAct_q;
      link.devCkOe <= portEn && isMaster;
      link.devDtOut <= shBit;
      link.devDtOe <= txActive;
    end
  end

  // Wake and interrupt requests
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeReq <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      wakeReq <= txFlag && irqCtl_q[sshd_pkg::IRQ_TRANSMIT_IRQ_ENABLE_BIT]
                 && irqCtl_q[sshd_pkg::IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
      irqReq <= txFlag && irqCtl_q[sshd_pkg::IRQ_TRANSMIT_IRQ_ENABLE_BIT]
                && irqCtl_q[sshd_pkg::IRQ_PERIPHERAL_IRQ_ENABLE_BIT] && irqCtl_q[sshd_pkg::IRQ_GIE_BIT];
    end
  end
endmodule // sshd_port

`default_nettype wire

// File: verilog/sshd_peer.sv
// Purpose: Far end of the clocked serial link: receives characters as master or slave
// Assumes: Lines sampled by two flip-flops; link half period from the package
// Notes: Never drives the data line
`default_nettype none

module sshd_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User control
  input wire logic asMaster,
  input wire logic polarity,
  input wire logic nineBits,
  input wire logic start,
  // User results
  output logic busy,
  output logic [8:0] rxWord,
  output logic rxValid,
  // Link
  sshd_if.peer link
);
  sshd_pkg::sshd_peer_state_e state_q;
  logic ckS1_q;
  logic ckS2_q;
  logic ckS3_q;
  logic dtS1_q;
  logic dtS2_q;
  logic [7:0] halfCnt_q;
  logic ckAct_q;
  logic [3:0] remain_q;
  logic [8:0] shift_q;
  logic [8:0] shiftNext;
  logic halfEnd;
  logic trail;

  assign halfEnd = (state_q == sshd_pkg::PS_RUN) && asMaster
                   && (halfCnt_q == sshd_pkg::PEER_HALF_CYC - 8'h01);
  assign shiftNext = {dtS2_q, shift_q[8:1]};

  // Sample on own trailing edge as master, on seen trailing edge as slave
  always_comb begin
    if (asMaster) begin
      trail = halfEnd && ckAct_q;
    end else begin
      trail = (state_q == sshd_pkg::PS_RUN) && !(ckS2_q ^ polarity) && (ckS3_q ^ polarity);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ckS1_q <= 1'b0;
      ckS2_q <= 1'b0;
      ckS3_q <= 1'b0;
      dtS1_q <= 1'b1;
      dtS2_q <= 1'b1;
    end else begin
      ckS1_q <= link.ck;
      ckS2_q <= ckS1_q;
      ckS3_q <= ckS2_q;
      dtS1_q <= link.dt;
      dtS2_q <= dtS1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sshd_pkg::PS_IDLE;
      halfCnt_q <= 8'h00;
      ckAct_q <= 1'b0;
      remain_q <= 4'h0;
      shift_q <= 9'h000;
      rxWord <= 9'h000;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      case (state_q)
        sshd_pkg::PS_IDLE: begin
          halfCnt_q <= 8'h00;
          ckAct_q <= 1'b0;
          if (start) begin
            remain_q <= nineBits ? sshd_pkg::LONG_BITS : sshd_pkg::CHAR_BITS;
            state_q <= sshd_pkg::PS_RUN;
          end
        end
        sshd_pkg::PS_RUN: begin
          if (halfEnd) begin
            halfCnt_q <= 8'h00;
            ckAct_q <= !ckAct_q;
          end else begin
            halfCnt_q <= halfCnt_q + 8'h01;
          end
          if (trail) begin
            shift_q <= shiftNext;
            remain_q <= remain_q - 4'h1;
            if (remain_q == 4'h1) begin
              rxWord <= nineBits ? shiftNext : {1'b0, shiftNext[8:1]};
              state_q <= sshd_pkg::PS_DONE;
            end
          end
        end
        sshd_pkg::PS_DONE: begin
          rxValid <= 1'b1;
          ckAct_q <= 1'b0;
          state_q <= sshd_pkg::PS_IDLE;
        end
        default: state_q <= sshd_pkg::PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      link.peerCkOut <= 1'b0;
      link.peerCkOe <= 1'b0;
      link.peerDtOut <= 1'b1;
      link.peerDtOe <= 1'b0;
    end else begin
      busy <= (state_q != sshd_pkg::PS_IDLE) || start;
      link.peerCkOut <= polarity ^ ckAct_q;
      link.peerCkOe <= asMaster;
      link.peerDtOut <= 1'b1;
      link.peerDtOe <= 1'b0;
    end
  end
endmodule // sshd_peer

`default_nettype wire

// File: dv/sshd_link_properties.sv
// Purpose: Link checks between the serial port and its far end
// Assumes: Bench divisors keep the device half period at 3 cycles or more
// Notes: A frame ends after 40 quiet cycles of the device clock
`default_nettype none

module sshd_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link lines
  input wire logic devCkOut,
  input wire logic devCkOe,
  input wire logic devDtOut,
  input wire logic devDtOe,
  input wire logic peerCkOut,
  input wire logic peerCkOe,
  input wire logic peerDtOut,
  input wire logic peerDtOe,
  input wire logic ck,
  input wire logic dt
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] QUIET = 6'h28;
  logic [5:0] quiet_q;
  logic [5:0] edges_q;
  logic [5:0] sinceCk_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Device clock edges per frame
  always_ff @(posedge clk) begin
    if (rst || !devCkOe) begin
      quiet_q <= 6'h00;
      edges_q <= 6'h00;
    end else if ($changed(devCkOut) && $past(devCkOe)) begin
      quiet_q <= 6'h00;
      edges_q <= edges_q + 6'h01;
    end else if (quiet_q != QUIET) begin
      quiet_q <= quiet_q + 6'h01;
    end else begin
      edges_q <= 6'h00;
    end
  end

  // Cycles since the shared clock moved
  always_ff @(posedge clk) begin
    if (rst || $changed(ck)) begin
      sinceCk_q <= 6'h00;
    end else if (sinceCk_q != 6'h3F) begin
      sinceCk_q <= sinceCk_q + 6'h01;
    end
  end

  data_excl_a: assert property (!(devDtOe && peerDtOe))
    else $error("both ends drive data");
  clock_excl_a: assert property (!(devCkOe && peerCkOe))
    else $error("both ends drive clock");
  peer_listen_a: assert property (!peerDtOe)
    else $error("far end drives data");
  // Odd edge count before an edge marks a trailing edge
  bit_hold_a: assert property ($changed(devCkOut) && devCkOe && $past(devCkOe)
    && edges_q[0] && devDtOe && $past(devDtOe) |-> $stable(devDtOut))
    else $error("data moved at trailing edge");
  lead_change_a: assert property (devCkOe && devDtOe && $past(devDtOe) && $changed(devDtOut)
    |-> $changed(devCkOut) && !edges_q[0]) else $error("data moved off leading edge");
  master_half_a: assert property ($changed(devCkOut) && devCkOe && $past(devCkOe)
    |=> $stable(devCkOut)[*2]) else $error("device half period short");
  frame_even_a: assert property (quiet_q == QUIET |-> !edges_q[0])
    else $error("clock not idle at its level");
  frame_len_a: assert property (edges_q <= 6'h24)
    else $error("too many clock edges");
  peer_half_a: assert property ($changed(peerCkOut) && peerCkOe && $past(peerCkOe)
    |=> $stable(peerCkOut)[*7]) else $error("far end half period short");
  slave_follow_a: assert property (peerCkOe && devDtOe && $past(devDtOe)
    && $changed(devDtOut) |-> sinceCk_q <= 6'h08) else $error("slave data without clock");
endmodule // sshd_link_checker

`default_nettype wire

// File: dv/sshd_tb_top.sv
// Purpose: Both link ends driven through APB and the far end user side
// Assumes: Far end answers as master at its own link rate, or as slave to the device clock
// Notes: Slave case runs last, with the far end driving the clock
`default_nettype none

module sshd_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, slvErr;
  logic sleep, wakeReq, irqReq, asMaster, polarity, nineBits, start, busy, rxValid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] rxWord;
  int n_mismatch, n_checks;
  localparam logic [23:0] RW_TAB [6] = '{{sshd_pkg::ADDR_BAUD_CTL, 8'hFF, 8'h18},
    {sshd_pkg::ADDR_RX_CTL, 8'hFF, 8'hB0}, {sshd_pkg::ADDR_DIV_LO, 8'hA5, 8'hA5},
    {sshd_pkg::ADDR_DIV_HI, 8'h5A, 8'h5A}, {sshd_pkg::ADDR_IRQ_CTL, 8'hFF, 8'h07},
    {sshd_pkg::ADDR_TX_HOLD, 8'h3C, 8'h00}};

  sshd_if link ();
  sshd_port sshd_port_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep(sleep), .wakeReq(wakeReq), .irqReq(irqReq), .link(link));
  sshd_peer sshd_peer_inst (.clk(clk), .rst(rst), .asMaster(asMaster), .polarity(polarity),
    .nineBits(nineBits), .start(start), .busy(busy), .rxWord(rxWord), .rxValid(rxValid),
    .link(link));
  sshd_link_checker sshd_link_checker_inst (.clk(clk), .rst(rst),
    .devCkOut(link.devCkOut), .devCkOe(link.devCkOe), .devDtOut(link.devDtOut),
    .devDtOe(link.devDtOe), .peerCkOut(link.peerCkOut), .peerCkOe(link.peerCkOe),
    .peerDtOut(link.peerDtOut), .peerDtOe(link.peerDtOe), .ck(link.ck), .dt(link.dt));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // Port disabled while clock level and mode change
  task automatic cfg(input logic [7:0] baud, input logic [7:0] lo, input logic [7:0] txc);
    wr(sshd_pkg::ADDR_RX_CTL, 8'h00);
    wr(sshd_pkg::ADDR_BAUD_CTL, baud);
    wr(sshd_pkg::ADDR_DIV_LO, lo);
    wr(sshd_pkg::ADDR_DIV_HI, 8'h00);
    wr(sshd_pkg::ADDR_TX_CTL, txc & 8'hDF);
    wr(sshd_pkg::ADDR_RX_CTL, 8'h80);
    wr(sshd_pkg::ADDR_TX_CTL, txc);
    repeat (3) @(posedge clk);
  endtask

  task automatic go(input logic m, input logic p, input logic nb);
    @(posedge clk);
    asMaster <= m;
    polarity <= p;
    nineBits <= nb;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk({31'h0, busy}, 32'h1);
  endtask

  task automatic rxWait(input logic [8:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rxValid !== 1'b1 && n < 4000);
    chk({22'h0, n < 4000, rxWord}, {22'h0, 1'b1, exp});
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    {rst, psel, penable, pwrite, sleep, asMaster, polarity, nineBits, start} = 9'h100;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk(rd & 32'hFFFFFFFD, 32'h0);
      chk({31'h0, slvErr}, {31'h0, i == 7});
    end
    for (int i = 0; i < 6; i++) begin
      wr(RW_TAB[i][23:16], RW_TAB[i][15:8]);
      rdChk(RW_TAB[i][23:16], {24'h0, RW_TAB[i][7:0]});
    end
    wr(sshd_pkg::ADDR_IRQ_CTL, 8'h00);
    // Master, 8 bits, two characters queued
    cfg(8'h00, 8'h07, 8'hB0);
    chk({30'h0, link.devCkOe, link.devDtOe}, 32'h3);
    go(1'b0, 1'b0, 1'b0);
    wr(sshd_pkg::ADDR_TX_HOLD, 8'hA5);
    wr(sshd_pkg::ADDR_TX_HOLD, 8'h3C);
    rdChk(sshd_pkg::ADDR_IRQ_CTL, 32'h0);
    rxWait(9'h0A5);
    go(1'b0, 1'b0, 1'b0);
    rdChk(sshd_pkg::ADDR_IRQ_CTL, 32'h8);
    rxWait(9'h03C);
    rdChk(sshd_pkg::ADDR_TX_CTL, 32'hB2);
    chk({31'h0, link.ck}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      wr(sshd_pkg::ADDR_IRQ_CTL, 8'(k));
      repeat (2) @(posedge clk);
      chk({30'h0, wakeReq, irqReq}, {30'h0, k[0] & k[1], k[0] & k[1] & k[2]});
    end
    // Master, 9 bits, clock idles high, wide divisor
    cfg(8'h18, 8'h06, 8'hF5);
    chk({31'h0, link.ck}, 32'h1);
    go(1'b0, 1'b1, 1'b1);
    wr(sshd_pkg::ADDR_TX_HOLD, 8'h5A);
    rxWait(9'h15A);
    chk({31'h0, link.ck}, 32'h1);
    rdChk(sshd_pkg::ADDR_TX_CTL, 32'hF7);
    // Receive direction and disabled port
    for (int i = 0; i < 3; i++) begin
      wr(sshd_pkg::ADDR_RX_CTL, (i == 2) ? 8'h00 : ((i == 0) ? 8'hA0 : 8'h90));
      repeat (3) @(posedge clk);
      chk({30'h0, link.devCkOe, link.devDtOe}, (i == 2) ? 32'h0 : 32'h2);
    end
    // Slave with two characters queued while asleep
    cfg(8'h00, 8'h07, 8'h30);
    chk({31'h0, link.devCkOe}, 32'h0);
    wr(sshd_pkg::ADDR_IRQ_CTL, 8'h03);
    sleep <= 1'b1;
    wr(sshd_pkg::ADDR_TX_HOLD, 8'h81);
    wr(sshd_pkg::ADDR_TX_HOLD, 8'h7E);
    rdChk(sshd_pkg::ADDR_IRQ_CTL, 32'h3);
    chk({31'h0, wakeReq}, 32'h0);
    go(1'b1, 1'b0, 1'b0);
    rxWait(9'h081);
    // Device sees the last trailing edge after its synchroniser
    repeat (4) @(posedge clk);
    rdChk(sshd_pkg::ADDR_IRQ_CTL, 32'hB);
    chk({31'h0, wakeReq}, 32'h1);
    go(1'b1, 1'b0, 1'b0);
    rxWait(9'h07E);
    sleep <= 1'b0;
    tally_and_finish;
  end
endmodule // sshd_tb_top

`default_nettype wire
